// >>> hw/fsi_encoder.sv
// power/fault indicator encoder: classifies relay condition, drives the two-colour lamp
// assumes detector inputs are asynchronous pins, store and recoverable code are on i_clock
`timescale 1ns/10ps
module fsi_encoder #(
  parameter int TICK_CYCLES = fsi_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_reset,
  // apb slave
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [7:0]          i_paddr,
  input  wire logic [31:0]         i_pwdata,
  output logic                     o_pready,
  output logic [31:0]              o_prdata,
  output logic                     o_pslverr,
  // detector pins and stored configuration
  input  wire fsi_pkg::fsi_pins_t   i_pins,
  input  wire fsi_pkg::fsi_stored_t i_stored,
  input  wire logic [2:0]          i_recover_code,
  // indicator and store write
  output logic                     o_power_fault_indicator_green,
  output logic                     o_power_fault_indicator_red,
  output fsi_pkg::fsi_cfg_wr_t      o_cfg_wr
);

  // refuse divider lengths the counter cannot hold
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  fsi_pkg::fsi_state_t q;
  fsi_pkg::fsi_state_t n;

  // next-state logic
  always_comb begin
    logic       tick;
    logic [3:0] cause_now;
    logic       dual;
    logic       mat_or;
    logic [2:0] eff;
    logic       setup;
    logic       access;
    logic       hit;
    logic [31:0] rd;
    tick      = 1'b0;
    cause_now = 4'h0;
    dual      = 1'b0;
    mat_or    = 1'b0;
    eff       = fsi_pkg::CODE_NONE;
    setup     = 1'b0;
    access    = 1'b0;
    hit       = 1'b0;
    rd        = 32'h0;
    n          = q;
    n.wr.store = 1'b0;

    // two-stage pin synchroniser
    n.s1 = i_pins;
    n.s2 = q.s1;

    // millisecond tick divider
    tick  = (q.div == 16'(TICK_CYCLES - 1));
    n.div = tick ? 16'h0 : q.div + 16'h1;

    // nonrecoverable causes by variant
    cause_now[0] = q.s2.test_pulse_source_short;
    cause_now[1] = q.s2.output_short && (q.variant == fsi_pkg::VAR_DUAL_SOLID);
    cause_now[2] = q.s2.excess_capacitance && (q.variant == fsi_pkg::VAR_SINGLE);
    cause_now[3] = q.s2.supply_disturbance;
    dual = (q.variant == fsi_pkg::VAR_DUAL_RELAY) || (q.variant == fsi_pkg::VAR_DUAL_SOLID);

    // condition machine
    case (q.mode)
      fsi_pkg::MODE_START: begin
        if (q.settle != 4'(fsi_pkg::SETTLE_CYCLES)) begin
          n.settle = q.settle + 4'h1;
        end else if (cause_now != 4'h0) begin
          n.mode = fsi_pkg::MODE_STEADY;
        end else begin
          case (i_stored.state)
            fsi_pkg::STORE_PENDING: begin
              if (q.s2.logic_switch >= fsi_pkg::LOGIC_MIN && q.s2.logic_switch <= fsi_pkg::LOGIC_MAX) begin
                // capture the switches set during configuration mode
                n.cfg_logic    = q.s2.logic_switch;
                n.cfg_link     = q.s2.retrigger_link_present;
                n.wr.store     = 1'b1;
                n.wr.state     = fsi_pkg::STORE_VALID;
                n.wr.logic_sel = q.s2.logic_switch;
                n.wr.link      = q.s2.retrigger_link_present;
                // odd position is OR, even is AND
                mat_or = dual && q.s2.logic_switch[0] && q.s2.mat_wiring && q.s2.inputs_closed;
                if (mat_or) begin
                  n.mode = fsi_pkg::MODE_FLASH;
                  n.code = fsi_pkg::CODE_MAT_OR;
                end else begin
                  n.mode = fsi_pkg::MODE_RUN;
                end
              end else begin
                n.mode = fsi_pkg::MODE_CONFIG;
              end
            end
            fsi_pkg::STORE_VALID: begin
              n.cfg_logic = i_stored.logic_sel;
              n.cfg_link  = i_stored.link;
              mat_or = dual && i_stored.logic_sel[0] && q.s2.mat_wiring && q.s2.inputs_closed;
              if (!i_stored.intact || q.s2.sources_swapped) begin
                n.mode = fsi_pkg::MODE_FLASH;
                n.code = fsi_pkg::CODE_BAD_CFG;
              end else if (mat_or) begin
                n.mode = fsi_pkg::MODE_FLASH;
                n.code = fsi_pkg::CODE_MAT_OR;
              end else if (q.variant == fsi_pkg::VAR_TIMED && q.s2.retrigger_link_present && !i_stored.link) begin
                n.mode = fsi_pkg::MODE_FLASH;
                n.code = fsi_pkg::CODE_MAT_OR;
              end else begin
                n.mode = fsi_pkg::MODE_RUN;
              end
            end
            default: begin
              // nothing stored: mark the attempt as pending
              n.mode         = fsi_pkg::MODE_CONFIG;
              n.wr.store     = 1'b1;
              n.wr.state     = fsi_pkg::STORE_PENDING;
              n.wr.logic_sel = 4'h0;
              n.wr.link      = 1'b0;
            end
          endcase
        end
      end
      fsi_pkg::MODE_RUN: begin
        if (q.s2.cross_fault) begin
          n.mode = fsi_pkg::MODE_FLASH;
          n.code = fsi_pkg::CODE_CROSS;
        end
      end
      default: begin
        // config, flash and steady hold until power cycle, a reconfiguration write or a steady cause
      end
    endcase

    // software reconfiguration request
    setup  = i_psel && !i_penable;
    access = i_psel && i_penable && q.pready;
    if (access && i_pwrite && i_paddr == fsi_pkg::ADDR_CTRL) begin
      n.variant = fsi_pkg::fsi_variant_t'(i_pwdata[fsi_pkg::CTRL_VARIANT_LSB +: 2]);
      if (i_pwdata[fsi_pkg::CTRL_RECONFIG_BIT] && q.mode != fsi_pkg::MODE_START) begin
        n.mode         = fsi_pkg::MODE_CONFIG;
        n.code         = fsi_pkg::CODE_NONE;
        n.cause        = 4'h0;
        n.wr.store     = 1'b1;
        n.wr.state     = fsi_pkg::STORE_PENDING;
        n.wr.logic_sel = 4'h0;
        n.wr.link      = 1'b0;
      end
    end

    // nonrecoverable causes latch and override everything
    if (q.mode != fsi_pkg::MODE_START && cause_now != 4'h0) begin
      n.cause = n.cause | cause_now;
      n.mode  = fsi_pkg::MODE_STEADY;
    end

    // code currently on display
    if (q.mode == fsi_pkg::MODE_FLASH) begin
      eff = q.code;
    end else if (q.mode == fsi_pkg::MODE_RUN) begin
      eff = i_recover_code;
    end

    // burst sequencer, restarts from a pause on a new code
    if (eff != q.shown) begin
      n.shown = eff;
      n.phase = fsi_pkg::PH_PAUSE;
      n.ms    = 11'h0;
      n.idx   = 3'h0;
    end else if (tick && eff != fsi_pkg::CODE_NONE) begin
      n.ms = q.ms + 11'h1;
      case (q.phase)
        fsi_pkg::PH_PAUSE: begin
          if (q.ms == 11'(fsi_pkg::PAUSE_MS - 1)) begin
            n.ms    = 11'h0;
            n.phase = fsi_pkg::PH_ON;
            n.idx   = 3'h1;
          end
        end
        fsi_pkg::PH_ON: begin
          if (q.ms == 11'(fsi_pkg::FLASH_ON_MS - 1)) begin
            n.ms    = 11'h0;
            n.phase = fsi_pkg::PH_OFF;
          end
        end
        default: begin
          if (q.ms == 11'(fsi_pkg::FLASH_OFF_MS - 1)) begin
            n.ms = 11'h0;
            if (q.idx == eff) begin
              n.phase = fsi_pkg::PH_PAUSE;
            end else begin
              n.phase = fsi_pkg::PH_ON;
              n.idx   = q.idx + 3'h1;
            end
          end
        end
      endcase
    end else if (tick && q.mode == fsi_pkg::MODE_CONFIG) begin
      // 1 Hz blink shares the millisecond counter
      if (q.ms == 11'(fsi_pkg::BLINK_HALF_MS - 1)) begin
        n.ms    = 11'h0;
        n.blink = !q.blink;
      end else begin
        n.ms = q.ms + 11'h1;
      end
    end
    if (q.mode != fsi_pkg::MODE_CONFIG) begin
      n.blink = 1'b0;
    end

    // lamp drive
    n.green = (q.mode == fsi_pkg::MODE_RUN);
    n.red   = (q.mode == fsi_pkg::MODE_STEADY)
           || (q.mode == fsi_pkg::MODE_CONFIG && q.blink)
           || (q.shown != fsi_pkg::CODE_NONE && q.phase == fsi_pkg::PH_ON);

    // apb read decode at setup, answer in the first access cycle
    n.pready  = setup;
    n.pslverr = 1'b0;
    if (setup) begin
      hit = 1'b1;
      if (i_paddr == fsi_pkg::ADDR_CTRL) begin
        rd[fsi_pkg::CTRL_VARIANT_LSB +: 2] = q.variant;
      end else if (i_paddr == fsi_pkg::ADDR_STATUS) begin
        rd[fsi_pkg::STATUS_MODE_LSB +: 3]  = q.mode;
        rd[fsi_pkg::STATUS_CODE_LSB +: 3]  = q.shown;
        rd[fsi_pkg::STATUS_CAUSE_LSB +: 4] = q.cause;
        rd[fsi_pkg::STATUS_RED_BIT]        = q.red;
        rd[fsi_pkg::STATUS_GREEN_BIT]      = q.green;
      end else if (i_paddr == fsi_pkg::ADDR_CONFIG) begin
        rd[fsi_pkg::CONFIG_LOGIC_LSB +: 4] = q.cfg_logic;
        rd[fsi_pkg::CONFIG_LINK_BIT]       = q.cfg_link;
      end else begin
        hit = 1'b0;
      end
      n.prdata  = rd;
      n.pslverr = !hit;
    end
  end

  // state register
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      q         <= '0;
      q.variant <= fsi_pkg::fsi_variant_t'(fsi_pkg::CTRL_VARIANT_RST);
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign o_pready                      = q.pready;
  assign o_prdata                      = q.prdata;
  assign o_pslverr                     = q.pslverr;
  assign o_power_fault_indicator_green = q.green;
  assign o_power_fault_indicator_red   = q.red;
  assign o_cfg_wr                      = q.wr;

  // helper terms for the checks
  logic steady_cause;
  logic start_go;
  assign steady_cause = q.s2.test_pulse_source_short || q.s2.supply_disturbance
                     || (q.s2.output_short && q.variant == fsi_pkg::VAR_DUAL_SOLID)
                     || (q.s2.excess_capacitance && q.variant == fsi_pkg::VAR_SINGLE);
  assign start_go     = (q.mode == fsi_pkg::MODE_START) && (q.settle == 4'(fsi_pkg::SETTLE_CYCLES));

  // steady red once entered
  sequence s_steady_hold;
    (q.mode == fsi_pkg::MODE_STEADY) [*3];
  endsequence

  property p_run_green;
    @(posedge i_clock) disable iff (i_reset)
    (q.mode == fsi_pkg::MODE_RUN && q.shown == fsi_pkg::CODE_NONE) |=> (o_power_fault_indicator_green && !o_power_fault_indicator_red);
  endproperty
  a_run_green: assert property (p_run_green) else $error("run without fault not steady green");

  property p_steady_red;
    @(posedge i_clock) disable iff (i_reset)
    (q.mode == fsi_pkg::MODE_STEADY) |=> (o_power_fault_indicator_red && !o_power_fault_indicator_green);
  endproperty
  a_steady_red: assert property (p_steady_red) else $error("steady fault not steady red");

  property p_recover_green;
    @(posedge i_clock) disable iff (i_reset)
    (q.mode == fsi_pkg::MODE_RUN && i_recover_code != fsi_pkg::CODE_NONE) |=> o_power_fault_indicator_green;
  endproperty
  a_recover_green: assert property (p_recover_green) else $error("recoverable fault lost green");

  property p_flash_no_green;
    @(posedge i_clock) disable iff (i_reset)
    (q.mode == fsi_pkg::MODE_FLASH) |=> !o_power_fault_indicator_green;
  endproperty
  a_flash_no_green: assert property (p_flash_no_green) else $error("flash code shows green");

  property p_pause_dark;
    @(posedge i_clock) disable iff (i_reset)
    (q.mode == fsi_pkg::MODE_FLASH && q.phase == fsi_pkg::PH_PAUSE) |=> !o_power_fault_indicator_red;
  endproperty
  a_pause_dark: assert property (p_pause_dark) else $error("red lit during pause");

  property p_config_blink;
    @(posedge i_clock) disable iff (i_reset)
    (q.mode == fsi_pkg::MODE_CONFIG && q.blink) |=> o_power_fault_indicator_red;
  endproperty
  a_config_blink: assert property (p_config_blink) else $error("config blink not shown");

  property p_empty_config;
    @(posedge i_clock) disable iff (i_reset)
    (start_go && !steady_cause && i_stored.state == fsi_pkg::STORE_EMPTY) |=> (q.mode == fsi_pkg::MODE_CONFIG && $past(n.wr.store));
  endproperty
  a_empty_config: assert property (p_empty_config) else $error("empty store did not enter config");

  property p_corrupt_two;
    @(posedge i_clock) disable iff (i_reset)
    (start_go && !steady_cause && i_stored.state == fsi_pkg::STORE_VALID && !i_stored.intact)
      |=> (q.mode == fsi_pkg::MODE_FLASH && q.code == fsi_pkg::CODE_BAD_CFG);
  endproperty
  a_corrupt_two: assert property (p_corrupt_two) else $error("corrupt store not two flashes");

  property p_cross_four;
    @(posedge i_clock) disable iff (i_reset)
    (q.mode == fsi_pkg::MODE_RUN && q.s2.cross_fault && !steady_cause)
      |=> (q.mode == fsi_pkg::MODE_FLASH && q.code == fsi_pkg::CODE_CROSS);
  endproperty
  a_cross_four: assert property (p_cross_four) else $error("cross fault not four flashes");

  property p_short_steady;
    @(posedge i_clock) disable iff (i_reset)
    (q.mode != fsi_pkg::MODE_START && q.s2.test_pulse_source_short) |=> s_steady_hold;
  endproperty
  a_short_steady: assert property (p_short_steady) else $error("source short not held steady red");

  property p_steady_holds;
    @(posedge i_clock) disable iff (i_reset)
    (q.mode == fsi_pkg::MODE_STEADY && !(i_psel && i_penable && i_pwrite)) |=> (q.mode == fsi_pkg::MODE_STEADY);
  endproperty
  a_steady_holds: assert property (p_steady_holds) else $error("steady red left without reset");

  property p_swap_two;
    @(posedge i_clock) disable iff (i_reset)
    (start_go && !steady_cause && i_stored.state == fsi_pkg::STORE_VALID && q.s2.sources_swapped)
      |=> (q.mode == fsi_pkg::MODE_FLASH && q.code == fsi_pkg::CODE_BAD_CFG);
  endproperty
  a_swap_two: assert property (p_swap_two) else $error("swapped sources not two flashes");

  property p_capture;
    @(posedge i_clock) disable iff (i_reset)
    (start_go && !steady_cause && i_stored.state == fsi_pkg::STORE_PENDING
      && q.s2.logic_switch >= fsi_pkg::LOGIC_MIN && q.s2.logic_switch <= fsi_pkg::LOGIC_MAX)
      |=> (o_cfg_wr.store && o_cfg_wr.state == fsi_pkg::STORE_VALID
      && o_cfg_wr.logic_sel == $past(q.s2.logic_switch));
  endproperty
  a_capture: assert property (p_capture) else $error("switch setting not captured");

  property p_link_three;
    @(posedge i_clock) disable iff (i_reset)
    (start_go && !steady_cause && i_stored.state == fsi_pkg::STORE_VALID && i_stored.intact
      && !q.s2.sources_swapped && q.variant == fsi_pkg::VAR_TIMED
      && q.s2.retrigger_link_present && !i_stored.link)
      |=> (q.mode == fsi_pkg::MODE_FLASH && q.code == fsi_pkg::CODE_MAT_OR);
  endproperty
  a_link_three: assert property (p_link_three) else $error("late retrigger link not three flashes");

  property p_output_steady;
    @(posedge i_clock) disable iff (i_reset)
    (q.mode != fsi_pkg::MODE_START && q.s2.output_short && q.variant == fsi_pkg::VAR_DUAL_SOLID)
      |=> (q.mode == fsi_pkg::MODE_STEADY && q.cause[1]);
  endproperty
  a_output_steady: assert property (p_output_steady) else $error("output short not steady red");

endmodule

// >>> hw/fsi_pkg.sv
// constants, types and register map of the power/fault indicator encoder
// assumes a 40 MHz core clock and a 32-bit apb master on the same clock
// Contract
// - run without fault shows steady green
// - undescribed nonrecoverable fault shows steady red
// - recoverable fault: green plus flashing red
// - ambiguous fault codes flash red without green
// - bursts repeat, separated by a pause
// - configuration mode blinks red at 1 Hz
// - no or unfinished configuration enters configuration mode
// - switches captured at power-up after configuration mode
// - corrupted stored setting flashes two
// - swapped test-pulse sources flash two
// - OR selector with mat wiring flashes three
// - mat mismatch reported once inputs are closed
// - AND selector accepts mat wiring
// - retrigger link added later flashes three
// - cross fault enters fault mode, flashes four
// - shorted test-pulse source gives steady red
// - shorted solid-state outputs give steady red
// - excess input capacitance gives steady red
// - supply or line disturbance gives steady red
// - steady red held until power cycle; a CTRL reconfiguration write also leaves it once the cause has gone
package fsi_pkg;
  // timing
  localparam int CLOCK_HZ       = 40_000_000;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = CLOCK_HZ / 1_000_000 * TICK_US;
  localparam int BLINK_HZ       = 1;
  localparam int BLINK_HALF_MS  = 1000 / (2 * BLINK_HZ);
  localparam int FLASH_ON_MS    = 250;
  localparam int FLASH_OFF_MS   = 250;
  localparam int PAUSE_MS       = 1500;
  localparam int SETTLE_CYCLES  = 4;
  // flash codes
  localparam logic [2:0] CODE_NONE    = 3'h0;
  localparam logic [2:0] CODE_BAD_CFG = 3'h2;
  localparam logic [2:0] CODE_MAT_OR  = 3'h3;
  localparam logic [2:0] CODE_CROSS   = 3'h4;
  // logic selector range
  localparam logic [3:0] LOGIC_MIN = 4'h1;
  localparam logic [3:0] LOGIC_MAX = 4'h8;
  // register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  // field positions
  localparam int CTRL_VARIANT_LSB  = 0;
  localparam int CTRL_RECONFIG_BIT = 8;
  localparam int STATUS_MODE_LSB   = 0;
  localparam int STATUS_CODE_LSB   = 4;
  localparam int STATUS_CAUSE_LSB  = 8;
  localparam int STATUS_RED_BIT    = 12;
  localparam int STATUS_GREEN_BIT  = 13;
  localparam int CONFIG_LOGIC_LSB  = 0;
  localparam int CONFIG_LINK_BIT   = 4;
  // reset values
  localparam logic [1:0] CTRL_VARIANT_RST = 2'h1;

  typedef enum logic [2:0] {MODE_START, MODE_CONFIG, MODE_RUN, MODE_FLASH, MODE_STEADY} fsi_mode_t;
  typedef enum logic [1:0] {PH_PAUSE, PH_ON, PH_OFF} fsi_phase_t;
  typedef enum logic [1:0] {VAR_SINGLE, VAR_DUAL_RELAY, VAR_DUAL_SOLID, VAR_TIMED} fsi_variant_t;
  typedef enum logic [1:0] {STORE_EMPTY, STORE_PENDING, STORE_VALID} fsi_store_t;

  // pin-level detector and switch inputs
  typedef struct packed {
    logic [3:0] logic_switch;
    logic       mat_wiring;
    logic       inputs_closed;
    logic       sources_swapped;
    logic       retrigger_link_present;
    logic       cross_fault;
    logic       test_pulse_source_short;
    logic       output_short;
    logic       excess_capacitance;
    logic       supply_disturbance;
  } fsi_pins_t;

  // stored configuration as read at power-up
  typedef struct packed {
    fsi_store_t state;
    logic       intact;
    logic [3:0] logic_sel;
    logic       link;
  } fsi_stored_t;

  // write request to the configuration store
  typedef struct packed {
    logic       store;
    fsi_store_t state;
    logic [3:0] logic_sel;
    logic       link;
  } fsi_cfg_wr_t;

  // whole state of the encoder
  typedef struct packed {
    fsi_pins_t    s1;
    fsi_pins_t    s2;
    fsi_mode_t    mode;
    logic [3:0]   settle;
    logic [15:0]  div;
    logic [10:0]  ms;
    fsi_phase_t   phase;
    logic [2:0]   idx;
    logic [2:0]   shown;
    logic         blink;
    logic [2:0]   code;
    logic [3:0]   cause;
    fsi_variant_t variant;
    logic [3:0]   cfg_logic;
    logic         cfg_link;
    fsi_cfg_wr_t  wr;
    logic         green;
    logic         red;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } fsi_state_t;
endpackage

// >>> sim/fsi_store_model.sv
// configuration store on the far side of the encoder, kept across power cycles
// assumes write requests and store contents share the encoder clock
`timescale 1ns/10ps
module fsi_store_model (
  // clock
  input  wire logic                 i_clock,
  // preset from the bench
  input  wire logic                 i_load,
  input  wire fsi_pkg::fsi_stored_t i_preset,
  // write request from the encoder
  input  wire fsi_pkg::fsi_cfg_wr_t i_cfg_wr,
  // contents seen at power-up
  output fsi_pkg::fsi_stored_t      o_stored
);
  // preset wins, else a write replaces the record and marks it intact
  always_ff @(posedge i_clock) begin
    if (i_load) begin
      o_stored <= i_preset;
    end else if (i_cfg_wr.store) begin
      o_stored <= '{i_cfg_wr.state, 1'b1, i_cfg_wr.logic_sel, i_cfg_wr.link};
    end
  end
endmodule

// >>> sim/tb.sv
// bench: power-up modes, flash codes, steady causes and apb map of the encoder
// assumes the store model holds the configuration between power cycles
`timescale 1ns/10ps
module tb;
  localparam int TK = 4;
  localparam logic [2:0] codes[5] = '{3'h2, 3'h2, 3'h4, 3'h3, 3'h0};
  localparam logic [1:0] vars[4] = '{2'h1, 2'h2, 2'h0, 2'h1};
  // stimulus and observed signals
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 psel = 1'b0;
  logic                 pen = 1'b0;
  logic                 pwr = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 green;
  logic                 red;
  logic                 load = 1'b0;
  logic [2:0]           rcode = 3'h0;
  fsi_pkg::fsi_pins_t   pins = '0;
  fsi_pkg::fsi_stored_t preset = '0;
  fsi_pkg::fsi_stored_t stored;
  fsi_pkg::fsi_cfg_wr_t cfg_wr;
  logic [31:0]          rd;
  logic                 err;
  int                   error_cnt = 0;
  int                   num_checks = 0;
  logic                 early = 1'b0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // design and store
  fsi_encoder #(.TICK_CYCLES(TK)) i_dut (.i_clock(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_pins(pins), .i_stored(stored), .i_recover_code(rcode),
    .o_power_fault_indicator_green(green), .o_power_fault_indicator_red(red), .o_cfg_wr(cfg_wr));
  fsi_store_model i_store (.i_clock(clk), .i_load(load), .i_preset(preset), .i_cfg_wr(cfg_wr),
    .o_stored(stored));

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out();
    end
  endtask

  // power cycle with given pins and optional store preset
  task automatic power_up(input logic ld, input fsi_pkg::fsi_stored_t st, input fsi_pkg::fsi_pins_t p);
    @(posedge clk);
    rst <= 1'b1;
    pins <= p;
    preset <= st;
    load <= ld;
    @(posedge clk);
    load <= 1'b0;
    repeat (11) @(posedge clk);
    rst <= 1'b0;
    // timed variant written before the start decision at the fifth edge
    if (early) begin
      apb(1'b1, fsi_pkg::ADDR_CTRL, 32'(fsi_pkg::VAR_TIMED));
    end
    repeat (30) @(posedge clk);
  endtask

  // count red rises and green cycles over a window
  task automatic watch(input int cyc, output int rises, output int greens);
    logic prev;
    prev = red;
    rises = 0;
    greens = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (red === 1'b1 && prev !== 1'b1)
        rises++;
      if (green === 1'b1)
        greens++;
      prev = red;
    end
  endtask

  // empty store, then capture of the switches at the next power-up
  task automatic t_config();
    int r, g;
    fsi_pkg::fsi_pins_t p;
    p = '0;
    power_up(1'b1, '0, p);
    apb(1'b0, fsi_pkg::ADDR_STATUS, 32'h0);
    chk("config mode", rd[2:0], fsi_pkg::MODE_CONFIG);
    chk("pending store", stored.state, fsi_pkg::STORE_PENDING);
    watch(2000 * TK, r, g);
    chk("config blinks", r, 2);
    chk("config green", g, 0);
    p.logic_switch = 4'h2;
    power_up(1'b0, '0, p);
    apb(1'b0, fsi_pkg::ADDR_CONFIG, 32'h0);
    chk("captured logic", rd, 32'h2);
    watch(100, r, g);
    chk("run green", g, 100);
    chk("run red", red, 1'b0);
    $display("test config done");
  endtask

  // flash codes from store and pin faults
  task automatic t_flash();
    int r, g;
    fsi_pkg::fsi_stored_t st;
    fsi_pkg::fsi_pins_t p;
    for (int k = 0; k < 5; k++) begin
      st = '{fsi_pkg::STORE_VALID, 1'b1, 4'h3, 1'b0};
      p = '0;
      p.logic_switch = 4'h3;
      p.inputs_closed = 1'b1;
      p.mat_wiring = (k >= 3);
      case (k)
        0: st.intact = 1'b0;
        1: p.sources_swapped = 1'b1;
        2: p.cross_fault = 1'b1;
        4: st.logic_sel = 4'h4;
        default: p.logic_switch = 4'h3;
      endcase
      power_up(1'b1, st, p);
      apb(1'b0, fsi_pkg::ADDR_STATUS, 32'h0);
      chk("flash code", rd[6:4], codes[k]);
      if (codes[k] != 3'h0) begin
        chk("flash mode", rd[2:0], fsi_pkg::MODE_FLASH);
        watch((1500 + 500 * codes[k]) * TK, r, g);
        chk("flash count", r, codes[k]);
        chk("flash green", g, 0);
      end else begin
        chk("mat and run", rd[2:0], fsi_pkg::MODE_RUN);
      end
    end
    $display("test flash done");
  endtask

  // recoverable code keeps green lit
  task automatic t_recover();
    int r, g;
    fsi_pkg::fsi_pins_t p;
    p = '0;
    p.logic_switch = 4'h2;
    power_up(1'b1, '{fsi_pkg::STORE_VALID, 1'b1, 4'h2, 1'b0}, p);
    rcode <= 3'h2;
    repeat (10) @(posedge clk);
    watch(2500 * TK, r, g);
    chk("recover flashes", r, 2);
    chk("recover green", g, 2500 * TK);
    rcode <= 3'h0;
    $display("test recover done");
  endtask

  // steady causes latch and survive removal of the cause
  task automatic t_steady();
    int r, g;
    fsi_pkg::fsi_pins_t p0, p;
    p0 = '0;
    p0.logic_switch = 4'h2;
    for (int i = 0; i < 4; i++) begin
      power_up(1'b1, '{fsi_pkg::STORE_VALID, 1'b1, 4'h2, 1'b0}, p0);
      apb(1'b1, fsi_pkg::ADDR_CTRL, {30'h0, vars[i]});
      p = p0;
      case (i)
        0: p.test_pulse_source_short = 1'b1;
        1: p.output_short = 1'b1;
        2: p.excess_capacitance = 1'b1;
        default: p.supply_disturbance = 1'b1;
      endcase
      pins <= p;
      repeat (10) @(posedge clk);
      pins <= p0;
      watch(200, r, g);
      chk("steady red", red, 1'b1);
      chk("steady dark green", g + r, 0);
      apb(1'b0, fsi_pkg::ADDR_STATUS, 32'h0);
      chk("steady mode", rd[2:0], fsi_pkg::MODE_STEADY);
      chk("steady cause", rd[11:8], 32'h1 << i);
    end
    power_up(1'b0, '0, p0);
    chk("run after cycle", green, 1'b1);
    $display("test steady done");
  endtask

  // register map, read-only places and an unmapped address
  task automatic t_apb();
    apb(1'b0, fsi_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h1);
    apb(1'b1, fsi_pkg::ADDR_STATUS, 32'hffff_ffff);
    chk("status write err", err, 1'b0);
    apb(1'b0, fsi_pkg::ADDR_STATUS, 32'h0);
    chk("status kept", rd[2:0], fsi_pkg::MODE_RUN);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    $display("test apb done");
  endtask

  // capture of an OR selector with mat wiring flashes three
  task automatic t_mat_capture();
    fsi_pkg::fsi_pins_t p;
    p = '0;
    p.logic_switch = 4'h3;
    p.mat_wiring = 1'b1;
    p.inputs_closed = 1'b1;
    power_up(1'b1, '{fsi_pkg::STORE_PENDING, 1'b1, 4'h0, 1'b0}, p);
    chk("captured store", stored, {fsi_pkg::STORE_VALID, 1'b1, 4'h3, 1'b0});
    apb(1'b0, fsi_pkg::ADDR_STATUS, 32'h0);
    chk("mat or code", rd[6:0], {fsi_pkg::CODE_MAT_OR, 1'b0, fsi_pkg::MODE_FLASH});
    $display("test mat capture done");
  endtask

  // retrigger link present but not stored on the timed variant
  task automatic t_late_link();
    fsi_pkg::fsi_pins_t p;
    p = '0;
    p.logic_switch = 4'h2;
    p.retrigger_link_present = 1'b1;
    early = 1'b1;
    power_up(1'b1, '{fsi_pkg::STORE_VALID, 1'b1, 4'h2, 1'b0}, p);
    early = 1'b0;
    apb(1'b0, fsi_pkg::ADDR_STATUS, 32'h0);
    chk("late link code", rd[6:0], {fsi_pkg::CODE_MAT_OR, 1'b0, fsi_pkg::MODE_FLASH});
    $display("test late link done");
  endtask

  // main sequence
  initial begin
    t_config();
    t_apb();
    t_flash();
    t_mat_capture();
    t_late_link();
    t_recover();
    t_steady();
    close_out();
  end
endmodule
